/* include/cfps_pkg.sv */
`default_nettype none
package cfps_pkg;
    localparam int          PC_W        = 21;
    localparam int          PTR_W       = 12;
    localparam int          LIT_W       = 6;
    localparam int          SEL_LSB     = 6;
    localparam logic [7:0]  SUB_OPCODE  = 8'hE9;
    localparam logic [PC_W-1:0] CALL_STEP = 21'h000004;
    localparam logic [1:0]  SEL_MAX     = 2'h2;
    localparam logic [PC_W-1:0] PC_RST  = 21'h000000;
    localparam logic [PTR_W-1:0] PTR_RST = 12'h000;
    localparam logic [7:0]  BYTE_RST    = 8'h00;

    // Four phases of one instruction cycle
    typedef enum logic [3:0]
    {
        CFPS_Q1 = 4'b0001,
        CFPS_Q2 = 4'b0010,
        CFPS_Q3 = 4'b0100,
        CFPS_Q4 = 4'b1000
    } cfps_phase_t;
endpackage : cfps_pkg
`default_nettype wire

/* rtl/cfps_core.sv */
`timescale 1ns/1ps
`default_nettype none
module cfps_core
    import cfps_pkg::*;
(
    input  wire logic              core_clk,
    input  wire logic              arst_n,
    input  wire logic              call_start,
    input  wire logic [19:0]       call_target,
    input  wire logic              call_fast,
    input  wire logic [PC_W-1:0]   call_pc,
    input  wire logic              sub_start,
    input  wire logic [15:0]       sub_word,
    input  wire logic [7:0]        work_in,
    input  wire logic [7:0]        bank_select_in,
    input  wire logic [7:0]        flags_in,
    output logic [PC_W-1:0]        pc_q,
    output logic [PC_W-1:0]        return_stack_top_q,
    output logic                   push_q,
    output logic [7:0]             work_shadow_q,
    output logic [7:0]             bank_select_shadow_q,
    output logic [7:0]             flags_shadow_q,
    output logic [PTR_W-1:0]       indirect_pointer0_q,
    output logic [PTR_W-1:0]       indirect_pointer1_q,
    output logic [PTR_W-1:0]       indirect_pointer2_q,
    output logic                   sub_done_q,
    output logic                   busy_q
);
    cfps_phase_t        phase_q;
    logic               sub_act_q;
    logic [1:0]         sel_q;
    logic [LIT_W-1:0]   lit_q;
    logic [PTR_W-1:0]   opnd_q;
    logic [PTR_W-1:0]   diff_q;
    logic               sub_hit;
    logic               call_take;
    logic               write_now;

    // Pick a pointer by select code; code 3 never reaches here
    function automatic logic [PTR_W-1:0] ptr_pick(input logic [1:0] s, input logic [PTR_W-1:0] a,
                                                  input logic [PTR_W-1:0] b, input logic [PTR_W-1:0] c);
        case (s)
            2'h0:    ptr_pick = a;
            2'h1:    ptr_pick = b;
            default: ptr_pick = c;
        endcase
    endfunction : ptr_pick

    // Select field of a subtract word
    function automatic logic [1:0] sub_sel(input logic [15:0] w);
        sub_sel = w[SEL_LSB+1:SEL_LSB];
    endfunction : sub_sel

    // Literal field of a subtract word
    function automatic logic [LIT_W-1:0] sub_lit(input logic [15:0] w);
        sub_lit = w[LIT_W-1:0];
    endfunction : sub_lit

    // Opcode match plus a legal select; code 3 belongs to the return variant
    function automatic logic sub_legal(input logic [15:0] w);
        sub_legal = (w[15:8] == SUB_OPCODE) && (sub_sel(w) <= SEL_MAX);
    endfunction : sub_legal

    // Decode only while idle, so a word offered mid-instruction is dropped
    assign sub_hit   = sub_start && !busy_q && sub_legal(sub_word);
    // A call is refused while a subtract owns the pointer path
    assign call_take = call_start && !busy_q;
    // Write-back slot of the fourth phase
    assign write_now = (phase_q == CFPS_Q4) && sub_act_q;

    // Call completes in one clock; all effects land together
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            pc_q               <= PC_RST;
            return_stack_top_q <= PC_RST;
            push_q             <= 1'b0;
        end
        else
        begin
            push_q <= call_take;
            if (call_take)
            begin
                pc_q               <= {call_target, 1'b0};
                return_stack_top_q <= call_pc + CALL_STEP;
            end
        end
    end

    // Shadows capture only with fast-save; otherwise held
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            work_shadow_q        <= BYTE_RST;
            bank_select_shadow_q <= BYTE_RST;
            flags_shadow_q       <= BYTE_RST;
        end
        else if (call_take && call_fast)
        begin
            work_shadow_q        <= work_in;
            bank_select_shadow_q <= bank_select_in;
            flags_shadow_q       <= flags_in;
        end
    end

    // Phase sequencer: decode, read, process, write; Q1 holds until a word is taken, then one step per clock
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            phase_q <= CFPS_Q1;
        end
        else
        begin
            case (phase_q)
                CFPS_Q1:
                begin
                    if (sub_hit)
                    begin
                        phase_q <= CFPS_Q2;
                    end
                end
                CFPS_Q2:
                begin
                    phase_q <= CFPS_Q3;
                end
                CFPS_Q3:
                begin
                    phase_q <= CFPS_Q4;
                end
                CFPS_Q4:
                begin
                    phase_q <= CFPS_Q1;
                end
                default:
                begin
                    phase_q <= CFPS_Q1;
                end
            endcase
        end
    end

    // Busy spans Q2 to Q4, set at the take in Q1, so no second word slips in
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            sub_act_q <= 1'b0;
            busy_q    <= 1'b0;
        end
        else if (phase_q == CFPS_Q1 && sub_hit)
        begin
            sub_act_q <= 1'b1;
            busy_q    <= 1'b1;
        end
        else if (phase_q == CFPS_Q4)
        begin
            sub_act_q <= 1'b0;
            busy_q    <= 1'b0;
        end
    end

    // Decode: select and literal are latched at the take
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            sel_q <= 2'h0;
            lit_q <= '0;
        end
        else if (phase_q == CFPS_Q1 && sub_hit)
        begin
            sel_q <= sub_sel(sub_word);
            lit_q <= sub_lit(sub_word);
        end
    end

    // Read: the selected pointer is sampled in the second phase
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            opnd_q <= PTR_RST;
        end
        else if (phase_q == CFPS_Q2)
        begin
            opnd_q <= ptr_pick(sel_q, indirect_pointer0_q, indirect_pointer1_q,
                               indirect_pointer2_q);
        end
    end

    // Process: modulo difference; no flag is ever computed
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            diff_q <= PTR_RST;
        end
        else if (phase_q == CFPS_Q3)
        begin
            diff_q <= opnd_q - {{(PTR_W-LIT_W){1'b0}}, lit_q};
        end
    end

    // Done pulse marks the write-back edge for one clock
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            sub_done_q <= 1'b0;
        end
        else
        begin
            sub_done_q <= write_now;
        end
    end

    // Write-back in Q4; flags are never touched here
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            indirect_pointer0_q <= PTR_RST;
            indirect_pointer1_q <= PTR_RST;
            indirect_pointer2_q <= PTR_RST;
        end
        else if (write_now)
        begin
            case (sel_q)
                2'h0:    indirect_pointer0_q <= diff_q;
                2'h1:    indirect_pointer1_q <= diff_q;
                default: indirect_pointer2_q <= diff_q;
            endcase
        end
    end
endmodule : cfps_core
`default_nettype wire

/* bench/cfps_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
module cfps_monitor
    import cfps_pkg::*;
(
    input wire logic             core_clk,
    input wire logic             arst_n,
    input wire logic             call_start,
    input wire logic             call_fast,
    input wire logic             sub_start,
    input wire logic             push_q,
    input wire logic             sub_done_q,
    input wire logic             busy_q,
    input wire logic [19:0]      call_target,
    input wire logic [PC_W-1:0]  call_pc,
    input wire logic [PC_W-1:0]  pc_q,
    input wire logic [PC_W-1:0]  return_stack_top_q,
    input wire logic [15:0]      sub_word,
    input wire logic [7:0]       work_in,
    input wire logic [7:0]       work_shadow_q,
    input wire logic [PTR_W-1:0] indirect_pointer0_q
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!arst_n);
    // Requests count only while the core is idle
    sequence s_call; call_start && !busy_q; endsequence
    sequence s_sub0; sub_start && !busy_q && sub_word[15:6] == {SUB_OPCODE, 2'h0}; endsequence
    property p_pc; s_call |=> pc_q == {$past(call_target), 1'b0}; endproperty
    a_pc: assert property (p_pc) else $error("pc load");
    property p_tos; s_call |=> push_q && return_stack_top_q == $past(call_pc) + CALL_STEP; endproperty
    a_tos: assert property (p_tos) else $error("stack push");
    property p_fast; s_call ##0 call_fast |=> work_shadow_q == $past(work_in); endproperty
    a_fast: assert property (p_fast) else $error("shadow copy");
    property p_keep; s_call ##0 !call_fast |=> $stable(work_shadow_q); endproperty
    a_keep: assert property (p_keep) else $error("shadow kept");
    // Write lands on the third edge after the take and is seen at the fourth sample
    property p_sub;
        s_sub0 |-> ##4 sub_done_q && indirect_pointer0_q == $past(indirect_pointer0_q, 4) - $past(sub_word[5:0], 4);
    endproperty
    a_sub: assert property (p_sub) else $error("subtract");
    property p_bad; sub_start && !busy_q && (sub_word[15:8] != SUB_OPCODE || sub_word[7:6] == 2'h3) |=> !busy_q; endproperty
    a_bad: assert property (p_bad) else $error("bad word taken");
    property p_pulse; sub_done_q |=> !sub_done_q; endproperty
    a_pulse: assert property (p_pulse) else $error("done width");
endmodule : cfps_monitor
bind cfps_core cfps_monitor u_mon
(
    .core_clk            (core_clk),
    .arst_n              (arst_n),
    .call_start          (call_start),
    .call_fast           (call_fast),
    .sub_start           (sub_start),
    .push_q              (push_q),
    .sub_done_q          (sub_done_q),
    .busy_q              (busy_q),
    .call_target         (call_target),
    .call_pc             (call_pc),
    .pc_q                (pc_q),
    .return_stack_top_q  (return_stack_top_q),
    .sub_word            (sub_word),
    .work_in             (work_in),
    .work_shadow_q       (work_shadow_q),
    .indirect_pointer0_q (indirect_pointer0_q)
);
`default_nettype wire

/* bench/tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb
    import cfps_pkg::*;
;
    logic core_clk = 1'b0, arst_n = 1'b0, call_start = 1'b0, call_fast = 1'b0, sub_start = 1'b0;
    logic [19:0] call_target = 20'h00000;
    logic [PC_W-1:0] call_pc = PC_RST, pc_q, return_stack_top_q;
    logic [15:0] sub_word = 16'h0000;
    logic [7:0] work_in = 8'hA5, bank_select_in = 8'h3C, flags_in = 8'h1E;
    logic [7:0] work_shadow_q, bank_select_shadow_q, flags_shadow_q;
    logic [PTR_W-1:0] indirect_pointer0_q, indirect_pointer1_q, indirect_pointer2_q, e;
    logic push_q, sub_done_q, busy_q;
    int mismatches = 0, total_checks = 0;
    cfps_core dut
    (
        .core_clk             (core_clk),
        .arst_n               (arst_n),
        .call_start           (call_start),
        .call_target          (call_target),
        .call_fast            (call_fast),
        .call_pc              (call_pc),
        .sub_start            (sub_start),
        .sub_word             (sub_word),
        .work_in              (work_in),
        .bank_select_in       (bank_select_in),
        .flags_in             (flags_in),
        .pc_q                 (pc_q),
        .return_stack_top_q   (return_stack_top_q),
        .push_q               (push_q),
        .work_shadow_q        (work_shadow_q),
        .bank_select_shadow_q (bank_select_shadow_q),
        .flags_shadow_q       (flags_shadow_q),
        .indirect_pointer0_q  (indirect_pointer0_q),
        .indirect_pointer1_q  (indirect_pointer1_q),
        .indirect_pointer2_q  (indirect_pointer2_q),
        .sub_done_q           (sub_done_q),
        .busy_q               (busy_q)
    );
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("wrong value at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk
    function automatic logic [PTR_W-1:0] ptr(input int s);
        return s == 0 ? indirect_pointer0_q : s == 1 ? indirect_pointer1_q : indirect_pointer2_q;
    endfunction : ptr
    task automatic summarize;
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : summarize
    // Shadows must follow the inputs only when fast-save is set
    task automatic test_call(input logic fast, input logic [19:0] k, input logic [PC_W-1:0] at);
        logic [23:0] old;
        old = {work_shadow_q, bank_select_shadow_q, flags_shadow_q};
        {call_target, call_pc, call_fast, call_start} = {k, at, fast, 1'b1};
        @(posedge core_clk) #10;
        call_start = 1'b0;
        chk(pc_q, {k, 1'b0});
        chk(return_stack_top_q, PC_W'(at + CALL_STEP));
        chk({work_shadow_q, bank_select_shadow_q, flags_shadow_q}, fast ? {work_in, bank_select_in, flags_in} : old);
        {work_in, bank_select_in, flags_in} = ~{work_in, bank_select_in, flags_in};
        chk(push_q, 1'b1);
        @(posedge core_clk) #10;
        chk(push_q, 1'b0);
        $display("call test done");
    endtask : test_call
    // Refused words must leave every pointer and the busy flag alone
    task automatic test_sub(input logic [7:0] op, input int sel, input logic [5:0] lit);
        int n;
        int s;
        int k;
        logic bad;
        logic [PTR_W-1:0] keep [3];
        bad = op !== SUB_OPCODE || sel == 3;
        s = sel == 3 ? 2 : sel;
        for (k = 0; k < 3; k++)
            keep[k] = ptr(k);
        e = bad ? ptr(s) : ptr(s) - lit;
        sub_word = {op, 2'(sel), lit};
        sub_start = 1'b1;
        @(posedge core_clk) #10;
        sub_start = 1'b0;
        chk(busy_q, !bad);
        for (n = 0; n < 8 && sub_done_q !== 1'b1; n++)
            @(posedge core_clk) #10;
        chk(n, bad ? 8 : 3);
        chk(ptr(s), e);
        for (k = 0; k < 3; k++)
            if (k != s)
                chk(ptr(k), keep[k]);
        if (n == 8 && !bad)
            summarize();
        @(posedge core_clk) #10;
        chk(sub_done_q, 1'b0);
        $display("subtract test done");
    endtask : test_sub
    // Free-running core clock
    initial
    begin
        forever #50 core_clk = ~core_clk;
    end
    // Main sequence; the first call also wraps the 21-bit push address
    initial
    begin
        repeat (10) @(posedge core_clk);
        #10 arst_n = 1'b1;
        test_call(1'b1, 20'hFFFFF, 21'h1FFFFC);
        test_call(1'b0, 20'h00001, 21'h000100);
        test_sub(SUB_OPCODE, 2, 6'h3F);
        test_sub(SUB_OPCODE, 2, 6'h23);
        test_sub(SUB_OPCODE, 0, 6'h01);
        test_sub(SUB_OPCODE, 1, 6'h2A);
        test_sub(SUB_OPCODE, 1, 6'h00);
        test_sub(SUB_OPCODE, 3, 6'h05);
        test_sub(8'hE8, 0, 6'h05);
        summarize();
    end
endmodule : tb
`default_nettype wire
